// File: dv/fssc_flash_model.sv
`timescale 1ns/1ps
module fssc_flash_model #(
  parameter int PROG_NS = 2000,
  parameter int HOLD_NS = 40
) (
  input  wire logic [19:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_dq_oe,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  output logic      [15:0] flash_dq_in,
  input  wire logic        fail_next,
  input  wire logic        protect
);
  logic        ready = 1'b1;
  logic        efail = 1'b0;
  logic        pfail = 1'b0;
  logic        sleep = 1'b0;
  // erase and its suspend are not modelled, so suspend stays clear
  logic        susp = 1'b0;
  logic        sleep_pend = 1'b0;
  logic        stat_mode = 1'b0;
  logic        prog_load = 1'b0;
  logic [1:0]  seq = 2'h0;
  logic [15:0] mem = 16'hFFFF;
  logic [15:0] drv = 16'h0000;
  logic [7:0]  d;
  int          gen = 0;
  int          rgen = 0;
  int          g;
  wire wr_n = flash_ce_n | flash_we_n;
  wire rd_n = flash_ce_n | flash_oe_n;
  function automatic logic [7:0] stat();
    return {ready, susp, efail, pfail, protect, sleep, 2'b00};
  endfunction
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : drv;
  always @(negedge rd_n) begin
    rgen++;
    drv = stat_mode ? {2{stat()}} : mem;
  end
  // released bus shows the inverse, so a late sample cannot pass by luck
  always @(posedge rd_n) begin
    rgen++;
    g = rgen;
    #(HOLD_NS);
    if (g == rgen) drv = ~drv;
  end
  task automatic run_op(input int tag);
    #(PROG_NS);
    if (tag == gen && !ready) begin
      ready = 1'b1;
      if (fail_next) pfail = 1'b1;
      if (sleep_pend) sleep = 1'b1;
      sleep_pend = 1'b0;
    end
  endtask
  always @(posedge wr_n) begin
    d = flash_dq_out[7:0];
    if (prog_load) begin
      prog_load = 1'b0;
      if (!(pfail || efail)) begin
        mem = flash_dq_out;
        ready = 1'b0;
        stat_mode = 1'b1;
        gen++;
        fork
          run_op(gen);
        join_none
      end
    end else if (seq == 2'h2) begin
      seq = 2'h0;
      case (d)
        8'hC0: if (!susp) begin
          stat_mode = 1'b1;
          if (ready) sleep = 1'b1;
          else sleep_pend = 1'b1;
        end
        8'hE0: if (!ready) begin
          gen++;
          ready = 1'b1;
          pfail = 1'b1;
          sleep = 1'b1;
          stat_mode = 1'b1;
        end
        8'hA0: prog_load = 1'b1;
        default: ;
      endcase
    end else if (seq == 2'h1) begin
      seq = (d == 8'h55 && flash_addr == 20'h02AAA) ? 2'h2 : 2'h0;
    end else if (d == 8'hAA && flash_addr == 20'h05555) begin
      seq = 2'h1;
    end else begin
      case (d)
        8'h70: stat_mode = 1'b1;
        8'hFF: begin
          stat_mode = 1'b0;
          sleep = 1'b0;
        end
        8'h50: begin
          efail = 1'b0;
          pfail = 1'b0;
        end
        default: ;
      endcase
    end
  end
endmodule

// File: dv/fssc_host_tb.sv
`timescale 1ns/1ps
module fssc_host_tb;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fail_next = 0, protect = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0]  htrans = 0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, dq_oe, ce_n, oe_n, we_n;
  wire  [19:0] faddr;
  wire  [15:0] dq_out, dq_in;
  int          fails = 0, check_count = 0;
  always #5 hclk = ~hclk;
  fssc_host fssc_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
    .flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
  fssc_flash_model fssc_flash_model_inst (.flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_dq_in(dq_in), .fail_next(fail_next),
    .protect(protect));
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task bad_wait;
    fails++;
    $display("[FAIL] wait bound expected done seen timeout");
    stop_test;
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) bad_wait;
    htrans <= 2'b00;
    hwdata <= d;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) bad_wait;
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task run(input logic [3:0] k);
    logic [31:0] r;
    int n;
    wr(8'h00, 32'h100 | {28'h0, k});
    n = 0;
    do begin ahb(1'b0, 8'h0C, 32'h0, r); n++; end while (r[0] !== 1'b0 && n < 100);
    if (n >= 100) bad_wait;
  endtask
  task poll(output logic [31:0] f);
    run(4'h6);
    ahb(1'b0, 8'h14, 32'h0, f);
  endtask
  task wait_ready(output logic [31:0] f);
    int n;
    n = 0;
    do begin poll(f); n++; end while (f[7] !== 1'b1 && n < 40);
    if (n >= 40) bad_wait;
  endtask
  task prog(input logic [19:0] a, input logic [15:0] d);
    wr(8'h04, {12'h0, a});
    wr(8'h08, {16'h0, d});
    run(4'h5);
  endtask
  function automatic logic [31:0] st(input logic rdy, input logic ef, input logic pf, input logic sl);
    return {24'h0, rdy, 1'b0, ef, pf, protect, sl, 2'b00};
  endfunction
  initial begin
    logic [31:0] f;
    logic [15:0] d;
    logic [19:0] a;
    void'($urandom(32'h56DA));
    protect = 1'($urandom);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    run(4'h1);
    poll(f);
    chk("flags after reset", f, st(1, 0, 0, 0));
    repeat (3) begin
      a = 20'($urandom);
      d = 16'($urandom);
      prog(a, d);
      poll(f);
      chk("busy flags", f, st(0, 0, 0, 0));
      wait_ready(f);
      chk("program done", f, st(1, 0, 0, 0));
      run(4'h0);
      wr(8'h04, {12'h0, a});
      run(4'h8);
      ahb(1'b0, 8'h10, 32'h0, f);
      chk("array word", f, {16'h0, d});
    end
    fail_next <= 1'b1;
    prog(20'h00100, 16'h1234);
    wait_ready(f);
    chk("program fail", f, st(1, 0, 1, 0));
    fail_next <= 1'b0;
    prog(20'h00200, 16'h5678);
    ahb(1'b0, 8'h0C, 32'h0, f);
    chk("refused", f & 32'h4, 32'h4);
    run(4'h1);
    poll(f);
    chk("fail sticky", f, st(1, 0, 1, 0));
    run(4'h2);
    run(4'h1);
    poll(f);
    chk("cleared", f, st(1, 0, 0, 0));
    prog(20'h00300, 16'h9ABC);
    run(4'h3);
    poll(f);
    chk("sleep while busy", f, st(0, 0, 0, 0));
    wait_ready(f);
    chk("sleep after op", f, st(1, 0, 0, 1));
    run(4'h0);
    run(4'h1);
    poll(f);
    chk("wake", f, st(1, 0, 0, 0));
    prog(20'h00400, 16'h0F0F);
    run(4'h4);
    poll(f);
    chk("abort", f, st(1, 0, 1, 1));
    run(4'h2);
    run(4'h0);
    run(4'h4);
    run(4'h1);
    poll(f);
    chk("idle abort", f, st(1, 0, 0, 0));
    wr(8'h04, 32'h05555);
    wr(8'h08, 32'h70);
    run(4'h7);
    run(4'h8);
    ahb(1'b0, 8'h10, 32'h0, f);
    chk("raw status", f, {16'h0, 8'(st(1, 0, 0, 0)), 8'(st(1, 0, 0, 0))});
    stop_test;
  end
  initial begin
    #900us;
    bad_wait;
  end
endmodule

// File: hw/fssc_host.sv
`timescale 1ns/1ps
`include "fssc_params.svh"
// Function
// - each status read is a separate enable pulse, enables go high between polls.
// - host issues clear-status after a failure before further program or erase.
// - host writes a read-type command before reading; not enforced, poll and raw-read kinds issue one bare read cycle.
// - sleep needs three write cycles, the last with sleep code.
// - host masks the two reserved low bits when polling.
module fssc_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [19:0] flash_addr,
  output logic      [15:0] flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n
);
  import fssc_pkg::*;

  localparam logic [3:0] PULSE_CYC = 4'(`FSSC_PULSE_CYC);
  localparam logic [3:0] GAP_CYC   = 4'(`FSSC_GAP_CYC);

  fssc_state_t state_reg;
  fssc_cycle_t cyc;
  logic [3:0]  kind_reg;
  logic [19:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [7:0]  flags_reg;
  logic        busy_reg;
  logic        refused_reg;
  logic        poll_ok_reg;
  logic [1:0]  step_reg;
  logic [1:0]  last_step;
  logic [3:0]  cnt_reg;
  logic [15:0] dq_sync;
  logic        dph_reg;
  logic        dph_wr_reg;
  logic [7:0]  dph_off_reg;
  logic        go;
  logic [7:0]  st_low;
  logic        fail_seen;

  fssc_sync2 #(.W(16)) u_dq_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (flash_dq_in),
    .q       (dq_sync)
  );

  // ahb-lite slave: zero wait states, always OKAY; read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_reg     <= 1'b0;
      dph_wr_reg  <= 1'b0;
      dph_off_reg <= 8'h00;
      hrdata      <= 32'h00000000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        // only whole-word transfers are accepted
        dph_reg     <= hsel & htrans[1] & (hsize == 3'h2);
        dph_wr_reg  <= hwrite;
        dph_off_reg <= haddr[7:0];
        case (haddr[7:0])
          `FSSC_OFF_ADDR:   hrdata <= {12'h000, addr_reg};
          `FSSC_OFF_WDATA:  hrdata <= {16'h0000, wdata_reg};
          `FSSC_OFF_STATUS: hrdata <= {28'h0000000, poll_ok_reg, refused_reg, 1'b0, busy_reg};
          `FSSC_OFF_RDATA:  hrdata <= {16'h0000, rdata_reg};
          `FSSC_OFF_FLAGS:  hrdata <= {24'h000000, flags_reg};
          default:          hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign go = dph_reg & dph_wr_reg & (dph_off_reg == `FSSC_OFF_CMD) & hwdata[`FSSC_CMD_GO_BIT] & ~busy_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg  <= 20'h00000;
      wdata_reg <= 16'h0000;
    end else if (dph_reg && dph_wr_reg) begin
      if (dph_off_reg == `FSSC_OFF_ADDR) begin
        addr_reg <= hwdata[19:0];
      end
      if (dph_off_reg == `FSSC_OFF_WDATA) begin
        wdata_reg <= hwdata[15:0];
      end
    end
  end

  // three-cycle sequences end in the command code; single cycles for read-type commands
  always_comb begin
    last_step = 2'd2;
    cyc = '{is_read: 1'b0, addr: `FSSC_UNLOCK1_ADDR, data: `FSSC_UNLOCK1_DATA};
    if (step_reg == 2'd1) begin
      cyc = '{is_read: 1'b0, addr: `FSSC_UNLOCK2_ADDR, data: `FSSC_UNLOCK2_DATA};
    end
    case (kind_reg)
      `FSSC_K_READ_ARRAY: begin
        last_step = 2'd0;
        cyc = '{is_read: 1'b0, addr: addr_reg, data: `FSSC_CODE_RD_ARRAY};
      end
      `FSSC_K_READ_STATUS: begin
        last_step = 2'd0;
        cyc = '{is_read: 1'b0, addr: addr_reg, data: `FSSC_CODE_RD_STATUS};
      end
      `FSSC_K_CLEAR_STATUS: begin
        last_step = 2'd0;
        cyc = '{is_read: 1'b0, addr: addr_reg, data: `FSSC_CODE_CLR_STAT};
      end
      `FSSC_K_SLEEP: begin
        if (step_reg == 2'd2) cyc = '{is_read: 1'b0, addr: `FSSC_UNLOCK1_ADDR, data: `FSSC_CODE_SLEEP};
      end
      `FSSC_K_ABORT: begin
        if (step_reg == 2'd2) cyc = '{is_read: 1'b0, addr: `FSSC_UNLOCK1_ADDR, data: `FSSC_CODE_ABORT};
      end
      `FSSC_K_PROGRAM_WORD: begin
        last_step = 2'd3;
        if (step_reg == 2'd2) cyc = '{is_read: 1'b0, addr: `FSSC_UNLOCK1_ADDR, data: `FSSC_CODE_PROGRAM};
        if (step_reg == 2'd3) cyc = '{is_read: 1'b0, addr: addr_reg, data: wdata_reg};
      end
      `FSSC_K_POLL, `FSSC_K_RAW_READ: begin
        last_step = 2'd0;
        cyc = '{is_read: 1'b1, addr: addr_reg, data: 16'h0000};
      end
      `FSSC_K_RAW_WRITE: begin
        last_step = 2'd0;
        cyc = '{is_read: 1'b0, addr: addr_reg, data: wdata_reg};
      end
      default: begin
        last_step = 2'd0;
      end
    endcase
  end

  // last known fail flags gate program starts so the host clears first
  assign fail_seen = flags_reg[`FSSC_ST_ERASE_FAIL] | flags_reg[`FSSC_ST_PROG_FAIL];

  // bus sequencer: every cycle ends with all enables high, so polls are separate pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= FSSC_IDLE;
      kind_reg  <= 4'h0;
      step_reg  <= 2'd0;
      cnt_reg   <= 4'h0;
      busy_reg  <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      case (state_reg)
        FSSC_IDLE: begin
          if (go) begin
            kind_reg <= hwdata[`FSSC_CMD_KIND_LSB +: 4];
            step_reg <= 2'd0;
            if (hwdata[`FSSC_CMD_KIND_LSB +: 4] == `FSSC_K_PROGRAM_WORD && fail_seen) begin
              refused_reg <= 1'b1;
            end else begin
              refused_reg <= 1'b0;
              busy_reg    <= 1'b1;
              state_reg   <= FSSC_SETUP;
            end
          end
        end
        FSSC_SETUP: begin
          cnt_reg   <= 4'h0;
          state_reg <= FSSC_STROBE;
        end
        FSSC_STROBE: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == PULSE_CYC - 4'h1) begin
            cnt_reg   <= 4'h0;
            state_reg <= FSSC_WAIT;
          end
        end
        FSSC_WAIT: begin
          state_reg <= FSSC_GAP;
        end
        FSSC_GAP: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == GAP_CYC - 4'h1) begin
            state_reg <= FSSC_NEXT;
          end
        end
        FSSC_NEXT: begin
          if (step_reg == last_step) begin
            state_reg <= FSSC_DONE;
          end else begin
            step_reg  <= step_reg + 2'd1;
            state_reg <= FSSC_SETUP;
          end
        end
        FSSC_DONE: begin
          busy_reg  <= 1'b0;
          state_reg <= FSSC_IDLE;
        end
        default: begin
          state_reg <= FSSC_IDLE;
        end
      endcase
    end
  end

  // pins come straight from flip-flops; the sync delay is covered by the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_addr   <= 20'h00000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe  <= 1'b0;
      flash_ce_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
      flash_we_n   <= 1'b1;
    end else begin
      flash_ce_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_we_n  <= 1'b1;
      flash_dq_oe <= 1'b0;
      if (state_reg == FSSC_SETUP || state_reg == FSSC_STROBE) begin
        flash_addr   <= cyc.addr;
        flash_dq_out <= cyc.data;
        flash_dq_oe  <= ~cyc.is_read;
      end
      if (state_reg == FSSC_STROBE && !(cnt_reg == PULSE_CYC - 4'h1)) begin
        flash_ce_n <= 1'b0;
        flash_oe_n <= ~cyc.is_read;
        flash_we_n <= cyc.is_read;
      end
    end
  end

  // read data sampled three clocks after the strobe so the synchroniser has settled
  assign st_low = dq_sync[7:0] & `FSSC_ST_RSVD_MASK;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg   <= 16'h0000;
      flags_reg   <= 8'h00;
      poll_ok_reg <= 1'b0;
    end else if (state_reg == FSSC_GAP && cnt_reg == 4'h1 && cyc.is_read) begin
      rdata_reg <= dq_sync;
      if (kind_reg == `FSSC_K_POLL) begin
        flags_reg   <= st_low;
        poll_ok_reg <= st_low[`FSSC_ST_READY];
      end
    end else if (state_reg == FSSC_DONE && kind_reg == `FSSC_K_CLEAR_STATUS) begin
      flags_reg[`FSSC_ST_ERASE_FAIL] <= 1'b0;
      flags_reg[`FSSC_ST_PROG_FAIL]  <= 1'b0;
    end
  end

  a_enable_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == FSSC_IDLE |-> flash_ce_n && flash_oe_n && flash_we_n)
    else $error("enables not idle high");
  a_no_read_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    !flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("drive during read");
  a_poll_separate: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(flash_oe_n) |-> flash_ce_n)
    else $error("read enables not released together");
  a_sleep_code: assert property (@(posedge hclk) disable iff (!hresetn)
    (kind_reg == `FSSC_K_SLEEP && step_reg == 2'd2 && !flash_we_n) |->
      flash_dq_out == `FSSC_CODE_SLEEP && flash_addr == `FSSC_UNLOCK1_ADDR)
    else $error("sleep code wrong");
  a_sleep_three: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == FSSC_DONE && kind_reg == `FSSC_K_SLEEP) |-> step_reg == 2'd2)
    else $error("sleep not three cycles");
  a_prog_refused: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == FSSC_IDLE && go && fail_seen && hwdata[3:0] == `FSSC_K_PROGRAM_WORD) |=> !busy_reg && refused_reg)
    else $error("program started with fail flag");
  a_read_cmd_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (kind_reg == `FSSC_K_READ_STATUS && !flash_we_n) |-> flash_dq_out == `FSSC_CODE_RD_STATUS)
    else $error("read-status code wrong");
  a_strobe_width: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(flash_ce_n) |-> !flash_ce_n [*8] ##1 !flash_ce_n ##1 !flash_ce_n ##1 !flash_ce_n ##1 flash_ce_n)
    else $error("strobe width wrong");
  a_mask_low: assert property (@(posedge hclk) disable iff (!hresetn)
    flags_reg[1:0] == 2'b00)
    else $error("reserved bits kept");
  c_sleep: cover property (@(posedge hclk) disable iff (!hresetn) state_reg == FSSC_DONE && kind_reg == `FSSC_K_SLEEP);
  c_poll: cover property (@(posedge hclk) disable iff (!hresetn) state_reg == FSSC_DONE && kind_reg == `FSSC_K_POLL);
  c_refuse: cover property (@(posedge hclk) disable iff (!hresetn) refused_reg);
endmodule

// File: hw/fssc_params.svh
`ifndef FSSC_PARAMS_SVH
`define FSSC_PARAMS_SVH
// controller register byte offsets
`define FSSC_OFF_CMD        8'h00
`define FSSC_OFF_ADDR       8'h04
`define FSSC_OFF_WDATA      8'h08
`define FSSC_OFF_STATUS     8'h0C
`define FSSC_OFF_RDATA      8'h10
`define FSSC_OFF_FLAGS      8'h14
// command register fields
`define FSSC_CMD_KIND_LSB   0
`define FSSC_CMD_GO_BIT     8
// command kinds
`define FSSC_K_READ_ARRAY   4'h0
`define FSSC_K_READ_STATUS  4'h1
`define FSSC_K_CLEAR_STATUS 4'h2
`define FSSC_K_SLEEP        4'h3
`define FSSC_K_ABORT        4'h4
`define FSSC_K_PROGRAM_WORD 4'h5
`define FSSC_K_POLL         4'h6
`define FSSC_K_RAW_WRITE    4'h7
`define FSSC_K_RAW_READ     4'h8
// flash command codes
`define FSSC_UNLOCK1_ADDR   20'h05555
`define FSSC_UNLOCK2_ADDR   20'h02AAA
`define FSSC_UNLOCK1_DATA   16'h00AA
`define FSSC_UNLOCK2_DATA   16'h0055
`define FSSC_CODE_SLEEP     16'h00C0
`define FSSC_CODE_ABORT     16'h00E0
`define FSSC_CODE_PROGRAM   16'h00A0
`define FSSC_CODE_RD_STATUS 16'h0070
`define FSSC_CODE_RD_ARRAY  16'h00FF
// clear-status code is not printed for the part, a local choice
`define FSSC_CODE_CLR_STAT  16'h0050
// status bit positions in the byte lane
`define FSSC_ST_READY       7
`define FSSC_ST_SUSPEND     6
`define FSSC_ST_ERASE_FAIL  5
`define FSSC_ST_PROG_FAIL   4
`define FSSC_ST_PROTECT     3
`define FSSC_ST_SLEEP       2
`define FSSC_ST_RSVD_MASK   8'hFC
// bus cycle timing, 10 ns clock
`define FSSC_CLK_NS         10
`define FSSC_PULSE_NS       120
`define FSSC_PULSE_CYC      ((`FSSC_PULSE_NS + `FSSC_CLK_NS - 1) / `FSSC_CLK_NS)
`define FSSC_GAP_NS         50
`define FSSC_GAP_CYC        ((`FSSC_GAP_NS + `FSSC_CLK_NS - 1) / `FSSC_CLK_NS)
`endif

// File: hw/fssc_pkg.sv
package fssc_pkg;
  typedef enum logic [6:0] {
    FSSC_IDLE   = 7'h01,
    FSSC_SETUP  = 7'h02,
    FSSC_STROBE = 7'h04,
    FSSC_GAP    = 7'h08,
    FSSC_NEXT   = 7'h10,
    FSSC_DONE   = 7'h20,
    FSSC_WAIT   = 7'h40
  } fssc_state_t;
  typedef struct packed {
    logic        is_read;
    logic [19:0] addr;
    logic [15:0] data;
  } fssc_cycle_t;
endpackage

// File: hw/fssc_sync2.sv
`timescale 1ns/1ps
module fssc_sync2 #(
  parameter int W = 16
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
